// File: common/sdrc_pkg.sv
// Package of register map, field layout and reset values for the read and timing configuration
package sdrc_pkg;
   localparam int unsigned ADDR_W           = 32;
   localparam int unsigned DATA_W           = 32;
   localparam int unsigned NUM_CS           = 4;

   localparam logic [31:0] READ_CFG_OFFSET  = 32'h3108_0028;
   localparam logic [31:0] PRE_OFFSET       = 32'h3108_0030;
   localparam logic [31:0] RAS_OFFSET       = 32'h3108_0034;
   localparam logic [31:0] SREX_OFFSET      = 32'h3108_0038;

   localparam int unsigned SDR_STRAT_LSB    = 0;
   localparam int unsigned SDR_EDGE_BIT     = 4;
   localparam int unsigned DDR_STRAT_LSB    = 8;
   localparam int unsigned DDR_EDGE_BIT     = 12;
   localparam int unsigned PRE_W            = 4;
   localparam int unsigned RAS_W            = 4;
   localparam int unsigned SREX_W           = 7;

   localparam logic [1:0]  STRAT_CLK_DLY    = 2'h0;
   localparam logic [1:0]  STRAT_CMD_DLY    = 2'h1;
   localparam logic [1:0]  STRAT_CMD_DLY_P1 = 2'h2;
   localparam logic [1:0]  STRAT_CMD_DLY_P2 = 2'h3;

   localparam logic        EDGE_RST         = 1'h0;
   localparam logic [1:0]  STRAT_RST        = 2'h0;
   localparam logic [3:0]  PRE_RST          = 4'hf;
   localparam logic [3:0]  RAS_RST          = 4'hf;
   localparam logic [6:0]  SREX_RST         = 7'h7f;

   localparam int unsigned WAIT_STATES      = 1;
endpackage

// File: src/sdrc_read_timing.sv
// Read capture, read strategy and per chip select timing counters of the dynamic memory controller
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module sdrc_read_timing
   import sdrc_pkg::*;
#(
   parameter int unsigned RD_W  = 32,
   parameter int unsigned CMD_W = 8
)(
   input  wire logic                 i_clk,
   input  wire logic                 i_reset,
   input  wire logic [ADDR_W-1:0]    i_addr,
   input  wire logic [DATA_W-1:0]    i_wdata,
   input  wire logic                 i_wr,
   input  wire logic                 i_rd,
   output logic      [DATA_W-1:0]    o_rdata,
   output logic                      o_ack,
   input  wire logic                 i_ddr_mode,
   input  wire logic [RD_W-1:0]      i_mem_dq,
   output logic      [RD_W-1:0]      o_rd_data,
   input  wire logic [CMD_W-1:0]     i_cmd,
   output logic      [CMD_W-1:0]     o_cmd,
   output logic                      o_clk_out_delayed,
   output logic                      o_cmd_delayed,
   input  wire logic [NUM_CS-1:0]    i_precharge_issued,
   input  wire logic [NUM_CS-1:0]    i_activate_issued,
   input  wire logic [NUM_CS-1:0]    i_self_refresh_exit,
   output logic      [NUM_CS-1:0]    o_bank_ready,
   output logic      [NUM_CS-1:0]    o_precharge_allowed,
   output logic      [NUM_CS-1:0]    o_srex_done
);

   logic              ddr_capture_edge_ff;
   logic [1:0]        ddr_read_strategy_ff;
   logic              sdr_capture_edge_ff;
   logic [1:0]        sdr_read_strategy_ff;
   logic [PRE_W-1:0]  precharge_period_ff;
   logic [RAS_W-1:0]  active_to_precharge_period_ff;
   logic [SREX_W-1:0] self_refresh_exit_time_ff;

   logic              sel_read_cfg;
   logic              sel_pre;
   logic              sel_ras;
   logic              sel_srex;
   logic [DATA_W-1:0] nxt_rdata;

   // Full address decode; any other address reads zero and is still acknowledged
   assign sel_read_cfg = (i_addr == READ_CFG_OFFSET);
   assign sel_pre      = (i_addr == PRE_OFFSET);
   assign sel_ras      = (i_addr == RAS_OFFSET);
   assign sel_srex     = (i_addr == SREX_OFFSET);

   // Configuration registers; the settings are not per chip select
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         ddr_capture_edge_ff  <= EDGE_RST;
         ddr_read_strategy_ff <= STRAT_RST;
         sdr_capture_edge_ff  <= EDGE_RST;
         sdr_read_strategy_ff <= STRAT_RST;
      end
      else if (i_wr && sel_read_cfg)
      begin
         ddr_capture_edge_ff  <= i_wdata[DDR_EDGE_BIT];
         ddr_read_strategy_ff <= i_wdata[DDR_STRAT_LSB +: 2];
         sdr_capture_edge_ff  <= i_wdata[SDR_EDGE_BIT];
         sdr_read_strategy_ff <= i_wdata[SDR_STRAT_LSB +: 2];
      end
   end

   // Timing values may change at any time; running counts keep their old load
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         precharge_period_ff <= PRE_RST;
      else if (i_wr && sel_pre)
         precharge_period_ff <= i_wdata[PRE_W-1:0];
   end

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         active_to_precharge_period_ff <= RAS_RST;
      else if (i_wr && sel_ras)
         active_to_precharge_period_ff <= i_wdata[RAS_W-1:0];
   end

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         self_refresh_exit_time_ff <= SREX_RST;
      else if (i_wr && sel_srex)
         self_refresh_exit_time_ff <= i_wdata[SREX_W-1:0];
   end

   // Unused and reserved bits read zero
   always_comb
   begin
      nxt_rdata = '0;
      if (sel_read_cfg)
      begin
         nxt_rdata[DDR_EDGE_BIT]       = ddr_capture_edge_ff;
         nxt_rdata[DDR_STRAT_LSB +: 2] = ddr_read_strategy_ff;
         nxt_rdata[SDR_EDGE_BIT]       = sdr_capture_edge_ff;
         nxt_rdata[SDR_STRAT_LSB +: 2] = sdr_read_strategy_ff;
      end
      else if (sel_pre)
         nxt_rdata[PRE_W-1:0] = precharge_period_ff;
      else if (sel_ras)
         nxt_rdata[RAS_W-1:0] = active_to_precharge_period_ff;
      else if (sel_srex)
         nxt_rdata[SREX_W-1:0] = self_refresh_exit_time_ff;
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         o_rdata <= '0;
      else if (i_rd)
         o_rdata <= nxt_rdata;
      else
         o_rdata <= '0;
   end

   // The acknowledge one cycle after the strobe is the single wait state
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         o_ack <= 1'h0;
      else
         o_ack <= (i_rd || i_wr);
   end

   // Capture on both edges; the falling-edge flop gives a half cycle of extra margin
   logic [RD_W-1:0] cap_neg_ff;
   logic [RD_W-1:0] cap_pos_ff;
   logic [RD_W-1:0] neg_hold_ff;
   logic [RD_W-1:0] pos_hold_ff;
   logic            use_rising;

   always_ff @(negedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         cap_neg_ff <= '0;
      else
         cap_neg_ff <= i_mem_dq;
   end

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         cap_pos_ff <= '0;
      else
         cap_pos_ff <= i_mem_dq;
   end

   // Second stage per edge; the selection reads only settled copies
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         neg_hold_ff <= '0;
      else
         neg_hold_ff <= cap_neg_ff;
   end

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         pos_hold_ff <= '0;
      else
         pos_hold_ff <= cap_pos_ff;
   end

   assign use_rising = i_ddr_mode ? ddr_capture_edge_ff : sdr_capture_edge_ff;

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         o_rd_data <= '0;
      else
         o_rd_data <= use_rising ? pos_hold_ff : neg_hold_ff;
   end

   // Strategy selection and extra command delay stages
   logic [1:0]       strategy;
   logic [CMD_W-1:0] cmd_d1_ff;
   logic [CMD_W-1:0] cmd_d2_ff;
   logic [CMD_W-1:0] nxt_cmd;

   assign strategy = i_ddr_mode ? ddr_read_strategy_ff : sdr_read_strategy_ff;

   // Two history stages give the one and two extra command cycles
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         cmd_d1_ff <= '0;
      else
         cmd_d1_ff <= i_cmd;
   end

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         cmd_d2_ff <= '0;
      else
         cmd_d2_ff <= cmd_d1_ff;
   end

   always_comb
   begin
      case (strategy)
         STRAT_CMD_DLY_P1: nxt_cmd = cmd_d1_ff;
         STRAT_CMD_DLY_P2: nxt_cmd = cmd_d2_ff;
         default:          nxt_cmd = i_cmd;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         o_cmd <= '0;
      else
         o_cmd <= nxt_cmd;
   end

   // Pad side picks clock delay or command delay from these two flags
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_clk_out_delayed <= 1'h1;
         o_cmd_delayed     <= 1'h0;
      end
      else
      begin
         o_clk_out_delayed <= (strategy == STRAT_CLK_DLY);
         o_cmd_delayed     <= (strategy != STRAT_CLK_DLY);
      end
   end

   // Per chip select timers, all loaded from the same shared fields
   genvar cs;
   generate
      for (cs = 0; cs < NUM_CS; cs++)
      begin : g_cs
         logic [PRE_W:0]  pre_cnt_ff;
         logic [RAS_W:0]  ras_cnt_ff;
         logic [SREX_W:0] srex_cnt_ff;
         logic [PRE_W:0]  nxt_pre_cnt;
         logic [RAS_W:0]  nxt_ras_cnt;
         logic [SREX_W:0] nxt_srex_cnt;

         // Field value n gives n+1 cycles; 0xF and 0x7F fall out as 16 and 128
         always_comb
         begin
            nxt_pre_cnt = pre_cnt_ff;
            if (i_precharge_issued[cs])
               nxt_pre_cnt = {1'h0, precharge_period_ff} + 1'h1;
            else if (pre_cnt_ff != '0)
               nxt_pre_cnt = pre_cnt_ff - 1'h1;
         end

         always_comb
         begin
            nxt_ras_cnt = ras_cnt_ff;
            if (i_activate_issued[cs])
               nxt_ras_cnt = {1'h0, active_to_precharge_period_ff} + 1'h1;
            else if (ras_cnt_ff != '0)
               nxt_ras_cnt = ras_cnt_ff - 1'h1;
         end

         always_comb
         begin
            nxt_srex_cnt = srex_cnt_ff;
            if (i_self_refresh_exit[cs])
               nxt_srex_cnt = {1'h0, self_refresh_exit_time_ff} + 1'h1;
            else if (srex_cnt_ff != '0)
               nxt_srex_cnt = srex_cnt_ff - 1'h1;
         end

         // Bank ready rises once the precharge period has run out
         always_ff @(posedge i_clk or posedge i_reset)
         begin
            if (i_reset)
            begin
               pre_cnt_ff       <= '0;
               o_bank_ready[cs] <= 1'h1;
            end
            else
            begin
               pre_cnt_ff       <= nxt_pre_cnt;
               o_bank_ready[cs] <= (nxt_pre_cnt == '0);
            end
         end

         // An open row may be closed only after the active period
         always_ff @(posedge i_clk or posedge i_reset)
         begin
            if (i_reset)
            begin
               ras_cnt_ff              <= '0;
               o_precharge_allowed[cs] <= 1'h1;
            end
            else
            begin
               ras_cnt_ff              <= nxt_ras_cnt;
               o_precharge_allowed[cs] <= (nxt_ras_cnt == '0);
            end
         end

         // Commands wait out the self-refresh exit time
         always_ff @(posedge i_clk or posedge i_reset)
         begin
            if (i_reset)
            begin
               srex_cnt_ff     <= '0;
               o_srex_done[cs] <= 1'h1;
            end
            else
            begin
               srex_cnt_ff     <= nxt_srex_cnt;
               o_srex_done[cs] <= (nxt_srex_cnt == '0);
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// File: tb/sdrc_mem_model.sv
// Memory read data model: a fresh word each half cycle, low bit tells the phase
`timescale 1ns/1ns
`default_nettype none
module sdrc_mem_model #(
   parameter int unsigned RD_W = 32
)(
   input  wire logic            i_clk,
   output logic      [RD_W-1:0] o_dq
);
   logic [RD_W-2:0] cnt_ff = '0;
   initial o_dq = '0;
   // Launched well after each edge so a capture at either edge sees a settled word
   always @(posedge i_clk)
   begin
      cnt_ff <= cnt_ff + 1'b1;
      o_dq   <= #25 {cnt_ff, 1'b0};
   end
   always @(negedge i_clk) o_dq <= #25 {cnt_ff, 1'b1};
endmodule
`default_nettype wire

// File: tb/sdrc_read_timing_checker.sv
// Checker of handshake, strategy outputs and timer starts
`timescale 1ns/1ns
`default_nettype none
module sdrc_read_timing_checker
   import sdrc_pkg::*;
#(
   parameter int unsigned CMD_W = 8
)(
   input wire logic              i_clk,
   input wire logic              i_reset,
   input wire logic              i_wr,
   input wire logic              i_rd,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic              i_ddr_mode,
   input wire logic [CMD_W-1:0]  i_cmd,
   input wire logic [NUM_CS-1:0] i_precharge_issued,
   input wire logic [NUM_CS-1:0] i_activate_issued,
   input wire logic [NUM_CS-1:0] i_self_refresh_exit,
   input wire logic              o_ack,
   input wire logic [CMD_W-1:0]  o_cmd,
   input wire logic              o_clk_out_delayed,
   input wire logic              o_cmd_delayed,
   input wire logic [NUM_CS-1:0] o_bank_ready,
   input wire logic [NUM_CS-1:0] o_precharge_allowed,
   input wire logic [NUM_CS-1:0] o_srex_done
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   chk_ack_one_wait: assert property ((i_wr || i_rd) |=> o_ack)
      else $error("no ack after strobe");
   chk_ack_no_extra: assert property (!(i_wr || i_rd) |=> !o_ack)
      else $error("ack without strobe");
   chk_strategy_excl: assert property (o_clk_out_delayed != o_cmd_delayed)
      else $error("strategy outputs disagree");
   chk_strategy_follow: assert property ((i_wr && i_addr == READ_CFG_OFFSET) |=> ##1
      o_cmd_delayed == ($past(i_ddr_mode)
         ? ($past(i_wdata[DDR_STRAT_LSB +: 2], 2) != STRAT_CLK_DLY)
         : ($past(i_wdata[SDR_STRAT_LSB +: 2], 2) != STRAT_CLK_DLY)))
      else $error("strategy flag wrong");
   chk_clkdly_path: assert property (o_clk_out_delayed && $past(o_clk_out_delayed)
      && $past(o_clk_out_delayed, 2) |-> o_cmd == $past(i_cmd)) else $error("cmd latency");
   chk_pre_start: assert property (i_precharge_issued[0] |=> !o_bank_ready[0])
      else $error("precharge timer idle");
   chk_ras_start: assert property (i_activate_issued[0] |=> !o_precharge_allowed[0])
      else $error("active timer idle");
   chk_srex_start: assert property (i_self_refresh_exit[0] |=> !o_srex_done[0])
      else $error("exit timer idle");
   chk_cs_alike: assert property (i_precharge_issued == '1 |=> o_bank_ready == '0)
      else $error("chip selects differ");
   chk_pre_rise_cause: assert property ($rose(o_bank_ready[0])
      |-> !$past(i_precharge_issued[0])) else $error("ready too early");
endmodule
bind sdrc_read_timing sdrc_read_timing_checker #(.CMD_W(CMD_W)) chk_inst (
   .i_clk(i_clk), .i_reset(i_reset), .i_wr(i_wr), .i_rd(i_rd), .i_cmd(i_cmd),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_ddr_mode(i_ddr_mode),
   .i_precharge_issued(i_precharge_issued), .i_activate_issued(i_activate_issued),
   .i_self_refresh_exit(i_self_refresh_exit), .o_ack(o_ack), .o_cmd(o_cmd),
   .o_clk_out_delayed(o_clk_out_delayed), .o_cmd_delayed(o_cmd_delayed),
   .o_bank_ready(o_bank_ready), .o_precharge_allowed(o_precharge_allowed),
   .o_srex_done(o_srex_done));
`default_nettype wire

// File: tb/test_sdrc_read_timing.sv
// Bench: register access, timers, capture edge and read strategy
`timescale 1ns/1ns
`default_nettype none
module test_sdrc_read_timing;
   import sdrc_pkg::*;
   logic              i_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_ddr_mode = 0;
   logic [31:0]       i_addr = '0, i_wdata = '0, o_rdata, rv, cfg, i_mem_dq, o_rd_data;
   logic [7:0]        i_cmd = '0, o_cmd;
   logic              o_ack, o_clk_out_delayed, o_cmd_delayed;
   logic [3:0]        tin [3], tout [3];
   logic [4:0]        act, oth;
   int                err_total = 0, n_checks = 0, n, v;
   localparam logic [31:0] TADR [3] = '{PRE_OFFSET, RAS_OFFSET, SREX_OFFSET};
   localparam int          TMAX [3] = '{15, 15, 127};
   always #50 i_clk = ~i_clk;
   sdrc_mem_model sdrc_mem_model_inst (.i_clk(i_clk), .o_dq(i_mem_dq));
   sdrc_read_timing sdrc_read_timing_inst (.i_clk(i_clk), .i_reset(i_reset),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_ack(o_ack), .i_ddr_mode(i_ddr_mode), .i_mem_dq(i_mem_dq), .o_rd_data(o_rd_data),
      .i_cmd(i_cmd), .o_cmd(o_cmd), .o_clk_out_delayed(o_clk_out_delayed),
      .o_cmd_delayed(o_cmd_delayed), .i_precharge_issued(tin[0]), .i_activate_issued(tin[1]),
      .i_self_refresh_exit(tin[2]), .o_bank_ready(tout[0]), .o_precharge_allowed(tout[1]),
      .o_srex_done(tout[2]));
   task automatic chk(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic wr, input logic [31:0] a, d);
      @(posedge i_clk);
      i_wr <= wr;
      i_rd <= !wr;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 0;
      i_rd <= 0;
      #1;
      chk(o_ack, 1);
      rv = o_rdata;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      foreach (tin[i]) tin[i] = '0;
      repeat (2) @(posedge i_clk);
      i_reset <= 0;
      acc(0, READ_CFG_OFFSET, 0);
      chk(rv, 0);
      // Only defined bits are written; reserved ones are left alone
      acc(1, READ_CFG_OFFSET, 32'h00001313);
      acc(0, READ_CFG_OFFSET, 0);
      chk(rv, 32'h00001313);
      acc(0, 32'h3108002c, 0);
      chk(rv, 0);
      foreach (TADR[t])
      begin
         acc(0, TADR[t], 0);
         chk(rv, TMAX[t]);
         acc(1, TADR[t], TMAX[t] - 1);
         acc(0, TADR[t], 0);
         chk(rv, TMAX[t] - 1);
      end
      $display("register test done");
      // Zero, five and the two highest values of each count
      foreach (TADR[t])
         for (int k = 0; k < 4; k++)
         begin
            v = (k < 2) ? k * 5 : TMAX[t] + k - 3;
            acc(1, TADR[t], v);
            @(posedge i_clk);
            tin[t] <= '1;
            @(posedge i_clk);
            tin[t] <= '0;
            #1;
            chk(tout[t], 4'h0);
            n = 0;
            while (tout[t][0] === 1'b0 && n < 300)
            begin
               n++;
               @(posedge i_clk);
               #1;
            end
            chk(n, v + 1);
            chk(tout[t], 4'hf);
         end
      $display("timer test done");
      // Unused mode's fields get the opposite settings so a wrong selection shows
      for (int m = 0; m < 2; m++)
         for (int s = 0; s < 4; s++)
         begin
            act = {s[0], 2'h0, s[1:0]};
            oth = {~s[0], 2'h0, ~s[1:0]};
            cfg = m ? {19'h0, act, 3'h0, oth} : {19'h0, oth, 3'h0, act};
            // Read configuration only changes right after a reset, as at start-up
            @(posedge i_clk);
            i_reset <= 1;
            i_ddr_mode <= m[0];
            @(posedge i_clk);
            i_reset <= 0;
            acc(1, READ_CFG_OFFSET, cfg);
            repeat (4) @(posedge i_clk);
            #1;
            chk(o_clk_out_delayed, s == 0);
            chk(o_cmd_delayed, s != 0);
            chk(o_rd_data[0], s[0]);
            @(posedge i_clk);
            i_cmd <= 8'ha5;
            @(posedge i_clk);
            i_cmd <= 8'h00;
            n = 1;
            #1;
            while (o_cmd !== 8'ha5 && n < 8)
            begin
               n++;
               @(posedge i_clk);
               #1;
            end
            chk(n, s < 2 ? 1 : s);
         end
      $display("strategy test done");
      end_sim;
   end
   // About twenty times the expected run length
   initial
   begin
      #1_000_000;
      err_total++;
      end_sim;
   end
endmodule
`default_nettype wire
